/* File: logic/spw_pkg.sv */
// Package of constants for the system pin wake, reset and erase block
package spw_pkg;
   // Main clock rate
   localparam int CLK_MHZ = 250;
   // Slow clock rate used to debounce the erase pin
   localparam int SLOW_HZ = 32768;
   // Number of wake-up inputs
   localparam int WAKE_N = 19;
   // Least low time of the driven reset pin, in ns
   localparam int RST_MIN_NS = 1000;
   // Cycles for the least reset pulse, rounded up
   localparam int RST_MIN_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
   // Erase pin ignore limit and guaranteed limit, in ms
   localparam int ERASE_IGNORE_MS = 100;
   localparam int ERASE_SURE_MS = 220;
   // Chosen threshold between the two limits, in ms
   localparam int ERASE_THR_MS = 160;
   // Threshold in slow clock cycles
   localparam int ERASE_THR_CYC = (SLOW_HZ * ERASE_THR_MS) / 1000;
   // Width of the debounce counter
   localparam int ERASE_CNT_W = 16;
   // Width of the reset pulse counter
   localparam int RST_CNT_W = 10;
   // Synchroniser lanes and their positions
   localparam int SYNC_N = 4;
   localparam int SYNC_SLOW = 0;
   localparam int SYNC_ERASE = 1;
   localparam int SYNC_RST = 2;
   localparam int SYNC_WAKE = 3;
   // Reset values of the synchronised lanes: reset pin idles high
   localparam logic [SYNC_N-1:0] SYNC_INIT = 4'h4;
endpackage : spw_pkg

/* File: logic/spw_erase_if.sv */
// Interface between the pin top and the erase debouncer
`timescale 1ns/1ns
`default_nettype none
interface spw_erase_if;
   logic level;      // Filtered erase pin level, system function only
   logic tick;       // One-cycle pulse per slow clock rising edge
   logic hit;        // One-cycle pulse when the threshold is reached
   modport owner (output level, output tick, input hit);
   modport debouncer (input level, input tick, output hit);
endinterface : spw_erase_if
`default_nettype wire

/* File: logic/spw_erase_debounce.sv */
// Slow clock debouncer for the erase request pin
`timescale 1ns/1ns
`default_nettype none
module spw_erase_debounce #(
   parameter logic [spw_pkg::ERASE_CNT_W-1:0] THR_CYC =
      spw_pkg::ERASE_CNT_W'(spw_pkg::ERASE_THR_CYC)
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Link to the pin top
   spw_erase_if.debouncer er
);
   ////////////////////////////////////////////////////////////////////////////
   logic [spw_pkg::ERASE_CNT_W-1:0] cnt_reg;  // Slow cycles seen high
   logic done_reg;                            // Threshold reached this hold
   logic hit_reg;                             // Output pulse

   // Count slow edges while high; any low level restarts the count
   always_ff @(posedge clk_i) begin
      if (reset_i || !er.level) begin
         cnt_reg <= '0;  // Glitch shorter than threshold is forgotten
      end else if (er.tick && cnt_reg != THR_CYC) begin
         cnt_reg <= cnt_reg + 1'b1;  // Counted on slow clock only
      end
   end

   // One request per hold; held pin does not retrigger
   always_ff @(posedge clk_i) begin
      if (reset_i || !er.level) begin
         done_reg <= 1'b0;
         hit_reg <= 1'b0;
      end else begin
         hit_reg <= (cnt_reg == THR_CYC) && !done_reg;  // Fixed threshold
         if (cnt_reg == THR_CYC) begin
            done_reg <= 1'b1;
         end
      end
   end

   assign er.hit = hit_reg;
endmodule : spw_erase_debounce
`default_nettype wire

/* File: logic/spw_pin_top.sv */
// System pin logic: fast wake-up, external reset pin and erase request pin
//
// Summary of operation
// - Low wake input during wait starts fast start-up
// - Wake detection is clockless, one request out
// - Request restarts RC oscillator, 4 MHz, CPU clock
// - Reset pin is bidirectional, either side pulls low
// - Pin reset hits core, peripherals, not backup
// - External low pulse of two or more cycles accepted; own drive held minimum
// - Reset pin is input after power-up
// - Valid erase returns flash to all ones
// - Erase pin sampled on main clock, debounced on slow clock
// - Erase high under 100 ms is ignored
// - Erase pin starts in system function
// - Erase pin as output never erases
// - Shared system pins start in system function
// - Valid erase clears every region lock bit
// - Security bit cleared only after full erase
`timescale 1ns/1ns
`default_nettype none
module spw_pin_top #(
   // Debounce threshold in slow clock cycles; shorten for simulation
   parameter int ERASE_THR_CYC = spw_pkg::ERASE_THR_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Wake-up inputs and power manager link
   input wire logic [spw_pkg::WAKE_N-1:0] wake_inputs_n_i,
   input wire logic wait_mode_i,
   output logic fast_startup_o,
   output logic rc_restart_o,
   output logic mck_rc4_sel_o,
   output logic cpu_clk_en_o,
   // External reset pin and reset controller
   input wire logic rstc_assert_i,
   input wire logic ext_rst_pin_i,
   output logic ext_rst_pin_o,
   output logic ext_rst_pin_oe_o,
   output logic core_periph_reset_o,
   // Slow clock sampled as a plain input
   input wire logic slow_clk_i,
   // Erase pin and flash controller link
   input wire logic erase_pin_i,
   input wire logic erase_gpio_sel_i,
   input wire logic erase_done_i,
   output logic erase_start_o,
   output logic lock_clear_o,
   output logic security_clear_o,
   output logic erase_busy_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Fast start-up request, no clock anywhere on this path
   logic wake_any;

   // Any low wake input while waiting raises the request at once
   assign wake_any = ~&wake_inputs_n_i;
   assign fast_startup_o = wake_any & wait_mode_i;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, three stages each
   logic [spw_pkg::SYNC_N-1:0] raw;       // Raw pin levels
   logic [spw_pkg::SYNC_N-1:0] s1_reg;    // First stage, read by s2 only
   logic [spw_pkg::SYNC_N-1:0] s2_reg;    // Second stage
   logic [spw_pkg::SYNC_N-1:0] s3_reg;    // Third stage
   logic [spw_pkg::SYNC_N-1:0] filt_reg;  // Accepted level

   assign raw[spw_pkg::SYNC_SLOW] = slow_clk_i;
   assign raw[spw_pkg::SYNC_ERASE] = erase_pin_i;
   assign raw[spw_pkg::SYNC_RST] = ext_rst_pin_i;
   assign raw[spw_pkg::SYNC_WAKE] = fast_startup_o;

   // A change counts once the second and third stages agree
   for (genvar g = 0; g < spw_pkg::SYNC_N; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
         if (reset_i) begin
            s1_reg[g] <= spw_pkg::SYNC_INIT[g];
            s2_reg[g] <= spw_pkg::SYNC_INIT[g];
            s3_reg[g] <= spw_pkg::SYNC_INIT[g];
            filt_reg[g] <= spw_pkg::SYNC_INIT[g];
         end else begin
            s1_reg[g] <= raw[g];
            s2_reg[g] <= s1_reg[g];
            s3_reg[g] <= s2_reg[g];
            if (s2_reg[g] == s3_reg[g]) begin
               filt_reg[g] <= s3_reg[g];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power manager reaction to the wake request
   logic wake_d_reg;  // Previous filtered wake level

   // Edge of the synchronised request starts the restart sequence
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wake_d_reg <= 1'b0;
         rc_restart_o <= 1'b0;
      end else begin
         wake_d_reg <= filt_reg[spw_pkg::SYNC_WAKE];
         rc_restart_o <= filt_reg[spw_pkg::SYNC_WAKE] & ~wake_d_reg;
      end
   end

   // Master clock held on the 4 MHz RC until wait mode is left
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mck_rc4_sel_o <= 1'b0;
      end else if (rc_restart_o) begin
         mck_rc4_sel_o <= 1'b1;  // Set wins over release
      end else if (!wait_mode_i) begin
         mck_rc4_sel_o <= 1'b0;
      end
   end

   // Processor clock stops on entry to wait, returns on wake
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cpu_clk_en_o <= 1'b1;
      end else if (rc_restart_o) begin
         cpu_clk_en_o <= 1'b1;
      end else if (wait_mode_i && !filt_reg[spw_pkg::SYNC_WAKE]) begin
         cpu_clk_en_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // External reset pin
   logic [spw_pkg::RST_CNT_W-1:0] rst_cnt_reg;  // Cycles left of own pulse

   // Own pulse lasts at least the minimum even if the request is brief
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rst_cnt_reg <= '0;  // Pin left as input after power-up
      end else if (rstc_assert_i) begin
         rst_cnt_reg <= spw_pkg::RST_CNT_W'(spw_pkg::RST_MIN_CYC);
      end else if (rst_cnt_reg != '0) begin
         rst_cnt_reg <= rst_cnt_reg - 1'b1;
      end
   end

   // Open-drain style drive: only ever pull low
   assign ext_rst_pin_o = 1'b0;
   assign ext_rst_pin_oe_o = (rst_cnt_reg != '0);

   // A low held two or more cycles on the pin resets core and peripherals; backup untouched
   // because no backup reset is produced here at all
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         core_periph_reset_o <= 1'b0;
      end else begin
         core_periph_reset_o <= ~filt_reg[spw_pkg::SYNC_RST];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Erase pin function select and slow clock edge
   logic gpio_mode_reg;  // Erase pin handed to general I/O
   logic slow_d_reg;     // Previous filtered slow clock

   // Comes up in system function; software moves it later
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         gpio_mode_reg <= 1'b0;
      end else begin
         gpio_mode_reg <= erase_gpio_sel_i;
      end
   end

   // Slow clock rising edge detector on the filtered level
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         slow_d_reg <= 1'b0;
      end else begin
         slow_d_reg <= filt_reg[spw_pkg::SYNC_SLOW];
      end
   end

   spw_erase_if er ();

   // In I/O mode the pin level never reaches the debouncer
   assign er.level = filt_reg[spw_pkg::SYNC_ERASE] & ~gpio_mode_reg;
   assign er.tick = filt_reg[spw_pkg::SYNC_SLOW] & ~slow_d_reg;

   spw_erase_debounce #(
      .THR_CYC(spw_pkg::ERASE_CNT_W'(ERASE_THR_CYC))
   ) u_debounce (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .er(er)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Erase sequencing toward the flash controller

   // Start full erase to all ones and unlock every region together
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         erase_start_o <= 1'b0;
         lock_clear_o <= 1'b0;
      end else begin
         erase_start_o <= er.hit & ~erase_busy_o;
         lock_clear_o <= er.hit & ~erase_busy_o;
      end
   end

   // Busy from start until the flash reports the full erase complete
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         erase_busy_o <= 1'b0;
      end else if (erase_start_o) begin
         erase_busy_o <= 1'b1;
      end else if (erase_done_i) begin
         erase_busy_o <= 1'b0;
      end
   end

   // Security clear only on completion of a pin-started erase
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         security_clear_o <= 1'b0;
      end else begin
         security_clear_o <= erase_busy_o & erase_done_i;
      end
   end
endmodule : spw_pin_top
`default_nettype wire

/* File: tb/spw_board.sv */
// Board model: reset pin wiring, erase pin and free slow clock
`timescale 1ns/1ns
`default_nettype none
module spw_board (
   // Main clock
   input wire logic clk_i,
   // Device reset drive and outside requests
   input wire logic rst_oe_i,
   input wire logic rst_val_i,
   input wire logic rst_pull_i,
   input wire logic erase_drv_i,
   // Pin levels seen by the device
   output logic rst_pin_o,
   output logic slow_clk_o,
   output logic erase_pin_o
);
   // Shortened slow clock, on odd ns only so it never lands on a main clock edge
   initial begin
      slow_clk_o = 1'b0;
      #1;
      forever #22 slow_clk_o = ~slow_clk_o;
   end
   // Wired low by either party, pull-up otherwise
   assign rst_pin_o = ((rst_oe_i && !rst_val_i) || rst_pull_i) ? 1'b0 : 1'b1;
   // Pull-down holds the erase pin low when not driven
   assign erase_pin_o = erase_drv_i ? 1'b1 : 1'b0;
endmodule : spw_board
`default_nettype wire

/* File: tb/spw_pin_top_checker.sv */
// Port checker of the system pin block
`timescale 1ns/1ns
`default_nettype none
module spw_pin_top_checker #(
   parameter int ERASE_THR_CYC = 4
) (
   // Ports watched
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [spw_pkg::WAKE_N-1:0] wake_inputs_n_i,
   input wire logic wait_mode_i,
   input wire logic fast_startup_o,
   input wire logic rc_restart_o,
   input wire logic mck_rc4_sel_o,
   input wire logic cpu_clk_en_o,
   input wire logic rstc_assert_i,
   input wire logic ext_rst_pin_i,
   input wire logic ext_rst_pin_o,
   input wire logic ext_rst_pin_oe_o,
   input wire logic core_periph_reset_o,
   input wire logic erase_gpio_sel_i,
   input wire logic erase_done_i,
   input wire logic erase_start_o,
   input wire logic lock_clear_o,
   input wire logic security_clear_o,
   input wire logic erase_busy_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // Length of the current own reset drive; saturates so a long drive never wraps
   logic [spw_pkg::RST_CNT_W-1:0] oe_len_reg;
   always_ff @(posedge clk_i) begin
      if (reset_i || !ext_rst_pin_oe_o) begin
         oe_len_reg <= '0;
      end else if (oe_len_reg != '1) begin
         oe_len_reg <= oe_len_reg + 1'b1;
      end
   end
   AST_WAKE_REQ: assert property (
      fast_startup_o == (!(&wake_inputs_n_i) && wait_mode_i)) else $error("bad wake request");
   AST_RC_ONE: assert property (
      rc_restart_o |=> !rc_restart_o && mck_rc4_sel_o && cpu_clk_en_o) else $error("bad restart");
   AST_RC_CAUSE: assert property (
      rc_restart_o |-> $past(fast_startup_o, 4)) else $error("restart without request");
   AST_OE_TAKE: assert property (
      rstc_assert_i |=> ext_rst_pin_oe_o) else $error("reset drive late");
   AST_OE_LOW: assert property (
      ext_rst_pin_oe_o |-> !ext_rst_pin_o) else $error("reset drive not low");
   AST_OE_MIN: assert property (
      $fell(ext_rst_pin_oe_o) |-> oe_len_reg >= spw_pkg::RST_CNT_W'(spw_pkg::RST_MIN_CYC))
      else $error("reset drive short");
   AST_CORE_RST: assert property (
      (!ext_rst_pin_i) [*7] |-> core_periph_reset_o) else $error("pin reset missed");
   AST_GPIO_NO: assert property (
      erase_gpio_sel_i [*6] |-> !erase_start_o) else $error("erase in io mode");
   AST_LOCK: assert property (
      erase_start_o == lock_clear_o) else $error("lock clear apart");
   AST_START: assert property (
      erase_start_o |=> erase_busy_o && !erase_start_o) else $error("bad erase start");
   AST_SEC: assert property (
      security_clear_o |-> $past(erase_done_i) && $past(erase_busy_o)) else $error("bad sec clear");
   // Main scenarios reached
   COV_RC: cover property (rc_restart_o);
   COV_ERASE: cover property (erase_start_o);
   COV_DRIVE: cover property ($fell(ext_rst_pin_oe_o));
endmodule : spw_pin_top_checker
bind spw_pin_top spw_pin_top_checker #(.ERASE_THR_CYC(ERASE_THR_CYC)) u_spw_pin_top_checker (.*);
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench of the system pin block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk_i, reset_i, wait_mode, rstc, pull, erase_drv, gpio, done, seen;
   logic [18:0] wake_n;
   logic rst_pin, slow_clk, erase_pin, fast, rcr, msel, cpu_en, pin_o, oe, core_rst;
   logic start, lock, sec, busy;
   int num_errors = 0, samples_checked = 0, starts = 0, secs = 0, rcs = 0, n, s0, r0;
   // Design with a short debounce threshold of 4 slow edges
   spw_pin_top #(.ERASE_THR_CYC(4)) u_spw_pin_top (
      .clk_i(clk_i), .reset_i(reset_i), .wake_inputs_n_i(wake_n), .wait_mode_i(wait_mode),
      .fast_startup_o(fast), .rc_restart_o(rcr), .mck_rc4_sel_o(msel), .cpu_clk_en_o(cpu_en),
      .rstc_assert_i(rstc), .ext_rst_pin_i(rst_pin), .ext_rst_pin_o(pin_o),
      .ext_rst_pin_oe_o(oe), .core_periph_reset_o(core_rst), .slow_clk_i(slow_clk),
      .erase_pin_i(erase_pin), .erase_gpio_sel_i(gpio), .erase_done_i(done),
      .erase_start_o(start), .lock_clear_o(lock), .security_clear_o(sec), .erase_busy_o(busy));
   spw_board u_spw_board (
      .clk_i(clk_i), .rst_oe_i(oe), .rst_val_i(pin_o), .rst_pull_i(pull),
      .erase_drv_i(erase_drv), .rst_pin_o(rst_pin), .slow_clk_o(slow_clk),
      .erase_pin_o(erase_pin));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // Count one-cycle pulses of the design
   always @(posedge clk_i) begin
      if (start === 1'b1) starts++;
      if (sec === 1'b1) secs++;
      if (rcr === 1'b1) rcs++;
   end
   task automatic chk(input string nm, input logic e, input logic s);
      samples_checked++;
      if (s !== e) begin
         num_errors++;
         $display("unexpected %s: expected %b seen %b", nm, e, s);
      end
   endtask : chk
   // Hold the erase pin high for n cycles, then low
   task automatic hold_erase(input int cyc);
      @(posedge clk_i);
      erase_drv <= 1'b1;
      repeat (cyc) @(posedge clk_i);
      erase_drv <= 1'b0;
      repeat (20) @(posedge clk_i);
      @(negedge clk_i);
   endtask : hold_erase
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : stop_test
   // Watchdog, far beyond the roughly 1200 cycles needed
   initial begin
      #100000;
      num_errors++;
      stop_test();
   end
   initial begin
      reset_i = 1'b1; wait_mode = 1'b0; rstc = 1'b0; pull = 1'b0; gpio = 1'b0; done = 1'b0;
      erase_drv = 1'b0;
      wake_n = 19'h7FFFF;
      void'($urandom(78));
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      @(negedge clk_i);
      chk("oe", 1'b0, oe);
      for (int k = 0; k < 19; k++) begin
         @(posedge clk_i) wait_mode <= 1'b1;
         repeat ($urandom_range(8, 12)) @(negedge clk_i);
         chk("cpu_en", 1'b0, cpu_en);
         @(posedge clk_i) wake_n <= ~(19'h00001 << k) & ((k % 2) ? 19'($urandom) : 19'h7FFFF);
         for (int i = 0; i < 12 && rcr !== 1'b1; i++) @(negedge clk_i);
         chk("fast", 1'b1, fast);
         chk("rc_restart", 1'b1, rcr);
         @(negedge clk_i);
         chk("mck_sel", 1'b1, msel);
         chk("cpu_en", 1'b1, cpu_en);
         @(posedge clk_i) wake_n <= 19'h7FFFF;
         wait_mode <= 1'b0;
         repeat (8) @(posedge clk_i);
      end
      r0 = rcs;
      wake_n <= 19'h00000;
      repeat (12) @(posedge clk_i);
      wake_n <= 19'h7FFFF;
      chk("no_wait_wake", 1'b1, rcs == r0);
      $display("wake test done");
      @(posedge clk_i) rstc <= 1'b1;
      @(posedge clk_i) rstc <= 1'b0;
      n = 0;
      seen = 1'b0;
      @(negedge clk_i);
      while (oe === 1'b1 && n < 400) begin
         n++;
         seen |= core_rst;
         @(negedge clk_i);
      end
      chk("oe_len", 1'b1, n >= spw_pkg::RST_MIN_CYC);
      chk("own_reset", 1'b1, seen);
      for (int j = 0; j < 3; j++) begin
         repeat (20) @(posedge clk_i);
         pull <= 1'b1;
         repeat ((j == 0) ? 3 : $urandom_range(4, 12)) @(posedge clk_i);
         pull <= 1'b0;
         seen = 1'b0;
         repeat (10) begin
            @(negedge clk_i);
            seen |= core_rst;
         end
         chk("pin_reset", 1'b1, seen);
      end
      $display("reset test done");
      s0 = starts;
      hold_erase(25);
      chk("short_erase", 1'b1, starts == s0);
      hold_erase(100);
      chk("erase_start", 1'b1, starts == s0 + 1);
      chk("busy", 1'b1, busy);
      chk("sec_early", 1'b1, secs == 0);
      @(posedge clk_i) done <= 1'b1;
      @(posedge clk_i) done <= 1'b0;
      repeat (3) @(negedge clk_i);
      chk("sec", 1'b1, secs == 1);
      chk("busy", 1'b0, busy);
      @(posedge clk_i) gpio <= 1'b1;
      hold_erase(100);
      chk("io_erase", 1'b1, starts == s0 + 1);
      $display("erase test done");
      stop_test();
   end
endmodule : testbench
`default_nettype wire
